// ===== logic/tbe_executor.sv
// Decode and execute of a subset of the twelve-bit instruction set
// Notes on behaviour
// - One instruction cycle is four clock periods.
// - One cycle per instruction; taken skips and jumps take two.
// - Byte ops: opcode 11..6, destination bit 5, register slot 4..0.
// - Bit ops: opcode 11..8, bit position 7..5, register slot 4..0.
// - Literal ops: opcode 11..8, eight-bit immediate 7..0.
// - Absolute jump: opcode 11..9, nine-bit immediate 8..0.
// - Destination 0 writes accumulator, 1 writes the file register.
// - Don't-care bits are ignored by decode.
// - Skip-on-low replaces next instruction with no-op when bit is zero.
// - Skip-on-high replaces next instruction with no-op when bit is one.
// - Invert stores complement per destination, updates null flag only.
// - Decrement stores minus one, null flag set on zero.
// - Decrement-skip stores minus one, no flags, skips on zero.
// - Jump loads immediate into counter bits 8..0, two cycles.
// - Jump loads counter bits 10..9 from status bits 6..5.
// - Increment stores plus one modulo 256, null flag on zero.
// - Register slot addresses one of 32 registers in the bank.
`include "tbe_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tbe_executor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [11:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] status_in,
  input wire logic [7:0] acc_in,
  output logic [4:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [7:0] acc_out,
  output logic acc_we,
  output logic null_flag,
  output logic null_we,
  output logic [10:0] pc_load,
  output logic pc_we,
  output logic fetch_req,
  output logic squash,
  output logic [11:0] pass_word,
  output logic pass_valid
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] phase;
    logic second;
    logic [4:0] file_addr;
    logic [7:0] file_wdata;
    logic file_we;
    logic [7:0] acc_out;
    logic acc_we;
    logic null_flag;
    logic null_we;
    logic [10:0] pc_load;
    logic pc_we;
    logic fetch_req;
    logic squash;
    logic [11:0] pass_word;
    logic pass_valid;
  } tbe_state_type;

  tbe_state_type cur;
  tbe_state_type next_cur;
  logic rst_n;
  logic [11:0] word;
  logic [7:0] res;
  logic [7:0] mask;
  logic take;
  logic is_byte;

  tbe_dec_if dif ();

  assign rst_n = cur.rst_sync[1];
  // In the second cycle of a taken skip or jump the word is a no-op
  assign word = cur.second ? `TBE_NOP_WORD : instr;

  tbe_decoder u_dec (
    .word(word),
    .d(dif.dec)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    mask = 8'h01 << dif.pos;
    res = file_rdata;
    take = 1'b0;
    is_byte = 1'b0;
    unique case (dif.op)
      tbe_pkg::TBE_OP_SETBIT: res = file_rdata | mask;
      tbe_pkg::TBE_OP_SKIPLOW: take = (file_rdata & mask) == 8'h00;
      tbe_pkg::TBE_OP_SKIPHIGH: take = (file_rdata & mask) != 8'h00;
      tbe_pkg::TBE_OP_INVERT: begin
        res = ~file_rdata;
        is_byte = 1'b1;
      end
      tbe_pkg::TBE_OP_DEC: begin
        res = file_rdata - 8'h01;
        is_byte = 1'b1;
      end
      tbe_pkg::TBE_OP_DECSKIP: begin
        res = file_rdata - 8'h01;
        is_byte = 1'b1;
        take = res == 8'h00;
      end
      tbe_pkg::TBE_OP_INC: begin
        res = file_rdata + 8'h01;
        is_byte = 1'b1;
      end
      tbe_pkg::TBE_OP_JUMP: take = 1'b1;
      tbe_pkg::TBE_OP_NONE: res = file_rdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    next_cur.rst_sync = {cur.rst_sync[0], 1'b1};
    next_cur.phase = cur.phase + 2'h1;
    next_cur.file_we = 1'b0;
    next_cur.acc_we = 1'b0;
    next_cur.null_we = 1'b0;
    next_cur.pc_we = 1'b0;
    next_cur.fetch_req = 1'b0;
    next_cur.squash = 1'b0;
    next_cur.pass_valid = 1'b0;
    next_cur.file_addr = dif.slot;
    if (cur.phase == `TBE_OSC_PER_CYC) begin
      next_cur.fetch_req = 1'b1;
      next_cur.second = take;
      next_cur.squash = take;
      next_cur.file_wdata = res;
      next_cur.acc_out = res;
      if (dif.op == tbe_pkg::TBE_OP_SETBIT) begin
        next_cur.file_we = 1'b1;
      end
      if (is_byte) begin
        next_cur.file_we = dif.dest;
        next_cur.acc_we = ~dif.dest;
      end
      if (dif.op == tbe_pkg::TBE_OP_INVERT || dif.op == tbe_pkg::TBE_OP_DEC ||
          dif.op == tbe_pkg::TBE_OP_INC) begin
        next_cur.null_we = 1'b1;
        next_cur.null_flag = res == 8'h00;
      end
      if (dif.op == tbe_pkg::TBE_OP_JUMP) begin
        next_cur.pc_we = 1'b1;
        next_cur.pc_load = {status_in[`TBE_PAGE_HI:`TBE_PAGE_LO], dif.k9};
      end
      if (dif.op == tbe_pkg::TBE_OP_NONE && !cur.second) begin
        next_cur.pass_word = instr;
        next_cur.pass_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else if (!rst_n) begin
      cur <= '0;
      cur.rst_sync <= {cur.rst_sync[0], 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign file_addr = cur.file_addr;
  assign file_wdata = cur.file_wdata;
  assign file_we = cur.file_we;
  assign acc_out = cur.acc_out;
  assign acc_we = cur.acc_we;
  assign null_flag = cur.null_flag;
  assign null_we = cur.null_we;
  assign pc_load = cur.pc_load;
  assign pc_we = cur.pc_we;
  assign fetch_req = cur.fetch_req;
  assign squash = cur.squash;
  assign pass_word = cur.pass_word;
  assign pass_valid = cur.pass_valid;

  ////////////////////////////////////////////////////////////////////////
  // End of an instruction cycle
  sequence cyc_end_s;
    cur.phase == `TBE_OSC_PER_CYC;
  endsequence

  // End of a cycle that runs a real word, not a squashed slot
  sequence live_end_s;
    cur.phase == `TBE_OSC_PER_CYC && !cur.second;
  endsequence

  sequence fetch_gap_s;
    fetch_req ##1 !fetch_req [*3] ##1 fetch_req;
  endsequence

  // Cycle end in which nothing is written, loaded or skipped
  sequence nop_cycle_s;
    fetch_req && !file_we && !acc_we && !null_we && !pc_we && !squash && !pass_valid;
  endsequence

  property fetch_every_four_p;
    @(posedge clk) disable iff (!rst_n) fetch_req |-> fetch_req ##0 fetch_gap_s;
  endproperty
  cycle_period_a: assert property (fetch_every_four_p)
    else $error("fetch spacing not four clocks");

  property pulse_with_fetch_p;
    @(posedge clk) disable iff (!rst_n)
      (file_we || acc_we || null_we || pc_we || squash || pass_valid) |-> fetch_req;
  endproperty
  pulse_fetch_a: assert property (pulse_with_fetch_p)
    else $error("result pulse outside cycle end");

  property skip_second_p;
    @(posedge clk) disable iff (!rst_n)
      squash |-> ##4 nop_cycle_s;
  endproperty
  skip_second_a: assert property (skip_second_p)
    else $error("cycle after skip not a no-op");

  property single_cycle_p;
    @(posedge clk) disable iff (!rst_n)
      live_end_s ##0 !(dif.op inside {tbe_pkg::TBE_OP_SKIPLOW, tbe_pkg::TBE_OP_SKIPHIGH,
      tbe_pkg::TBE_OP_DECSKIP, tbe_pkg::TBE_OP_JUMP}) |=> !squash;
  endproperty
  single_cycle_a: assert property (single_cycle_p)
    else $error("plain word took two cycles");

  property slot_field_p;
    @(posedge clk) disable iff (!rst_n)
      live_end_s |=> file_addr == $past(instr[`TBE_SLOT_HI:0]);
  endproperty
  slot_field_a: assert property (slot_field_p)
    else $error("register slot wrong");

  property dest_select_p;
    @(posedge clk) disable iff (!rst_n)
      live_end_s ##0 is_byte |=>
      file_we == $past(instr[`TBE_DEST_BIT]) && acc_we == !$past(instr[`TBE_DEST_BIT]);
  endproperty
  dest_select_a: assert property (dest_select_p)
    else $error("destination select wrong");

  property set_bit_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_SETBIT) |=>
      file_we && !acc_we && !null_we && !squash && (file_wdata & $past(file_rdata)) ==
      $past(file_rdata) && file_wdata[$past(instr[`TBE_POS_HI:`TBE_POS_LO])];
  endproperty
  set_bit_a: assert property (set_bit_p)
    else $error("bit set wrong");

  property skip_low_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_SKIPLOW) |=>
      squash == !$past(file_rdata[instr[`TBE_POS_HI:`TBE_POS_LO]]) && !file_we && !acc_we;
  endproperty
  skip_low_a: assert property (skip_low_p)
    else $error("skip on low wrong");

  property skip_high_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_SKIPHIGH) |=>
      squash == $past(file_rdata[instr[`TBE_POS_HI:`TBE_POS_LO]]) && !file_we && !null_we;
  endproperty
  skip_high_a: assert property (skip_high_p)
    else $error("skip on high wrong");

  property invert_file_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_INVERT) |=>
      null_we && !squash && file_wdata == ~$past(file_rdata) &&
      null_flag == ($past(file_rdata) == 8'hFF);
  endproperty
  invert_file_a: assert property (invert_file_p)
    else $error("invert result wrong");

  property dec_null_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_DEC) |=>
      null_we && !squash && file_wdata == $past(file_rdata) - 8'h01 &&
      null_flag == ($past(file_rdata) == 8'h01);
  endproperty
  dec_null_a: assert property (dec_null_p)
    else $error("decrement result wrong");

  property dec_skip_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_DECSKIP) |=>
      !null_we && squash == ($past(file_rdata) == 8'h01) &&
      file_wdata == $past(file_rdata) - 8'h01;
  endproperty
  dec_skip_a: assert property (dec_skip_p)
    else $error("decrement skip wrong");

  property inc_value_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_INC) |=>
      null_we && !squash && file_wdata == $past(file_rdata) + 8'h01 &&
      null_flag == ($past(file_rdata) == 8'hFF);
  endproperty
  inc_value_a: assert property (inc_value_p)
    else $error("increment result wrong");

  property inc_null_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_INC && file_rdata == 8'hFF) |=>
      null_we && null_flag && file_wdata == 8'h00;
  endproperty
  inc_null_a: assert property (inc_null_p)
    else $error("increment wrap wrong");

  property jump_load_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_JUMP) |=>
      pc_we && squash && !file_we && !acc_we && !null_we &&
      pc_load[`TBE_K9_HI:0] == $past(instr[`TBE_K9_HI:0]);
  endproperty
  jump_load_a: assert property (jump_load_p)
    else $error("jump target wrong");

  property jump_page_p;
    @(posedge clk) disable iff (!rst_n)
      cyc_end_s ##0 (dif.op == tbe_pkg::TBE_OP_JUMP) |=>
      pc_load[`TBE_PCPG_HI:`TBE_PCPG_LO] == $past(status_in[`TBE_PAGE_HI:`TBE_PAGE_LO]);
  endproperty
  jump_page_a: assert property (jump_page_p)
    else $error("jump page wrong");

  property pass_word_p;
    @(posedge clk) disable iff (!rst_n)
      live_end_s ##0 (dif.op == tbe_pkg::TBE_OP_NONE) |=>
      pass_valid && pass_word == $past(instr);
  endproperty
  pass_word_a: assert property (pass_word_p)
    else $error("passed word wrong");

  property pass_quiet_p;
    @(posedge clk) disable iff (!rst_n)
      pass_valid |-> !file_we && !acc_we && !null_we && !pc_we;
  endproperty
  pass_quiet_a: assert property (pass_quiet_p)
    else $error("passed opcode altered state");
endmodule : tbe_executor
`default_nettype wire

// ===== logic/tbe_map.svh
// Constants for the twelve-bit instruction executor
`ifndef TBE_MAP_SVH
`define TBE_MAP_SVH
`define TBE_OSC_PER_CYC 2'h3
`define TBE_OP6_HI 11
`define TBE_OP6_LO 6
`define TBE_DEST_BIT 5
`define TBE_SLOT_HI 4
`define TBE_OP4_LO 8
`define TBE_POS_HI 7
`define TBE_POS_LO 5
`define TBE_OP3_LO 9
`define TBE_K9_HI 8
`define TBE_OP6_INVERT 6'h09
`define TBE_OP6_DEC 6'h03
`define TBE_OP6_DECSKIP 6'h0B
`define TBE_OP6_INC 6'h0A
`define TBE_OP4_SETBIT 4'h5
`define TBE_OP4_SKIPLOW 4'h6
`define TBE_OP4_SKIPHIGH 4'h7
`define TBE_OP3_JUMP 3'h5
`define TBE_PAGE_HI 6
`define TBE_PAGE_LO 5
`define TBE_PCPG_HI 10
`define TBE_PCPG_LO 9
`define TBE_NULL_BIT 2
`define TBE_NOP_WORD 12'h000
`endif

// ===== logic/tbe_pkg.sv
// Types for the twelve-bit instruction executor
package tbe_pkg;
  typedef enum logic [8:0] {
    TBE_OP_NONE = 9'h001,
    TBE_OP_SETBIT = 9'h002,
    TBE_OP_SKIPLOW = 9'h004,
    TBE_OP_SKIPHIGH = 9'h008,
    TBE_OP_INVERT = 9'h010,
    TBE_OP_DEC = 9'h020,
    TBE_OP_DECSKIP = 9'h040,
    TBE_OP_INC = 9'h080,
    TBE_OP_JUMP = 9'h100
  } tbe_op_type;
endpackage : tbe_pkg

// ===== logic/tbe_dec_if.sv
// Decoded fields passed from decoder to executor
`timescale 1ns/10ps
`default_nettype none
interface tbe_dec_if;
  tbe_pkg::tbe_op_type op;
  logic dest;
  logic [4:0] slot;
  logic [2:0] pos;
  logic [8:0] k9;
  modport dec (output op, dest, slot, pos, k9);
  modport exe (input op, dest, slot, pos, k9);
endinterface : tbe_dec_if
`default_nettype wire

// ===== logic/tbe_decoder.sv
// Field extraction and opcode decode of one instruction word
`include "tbe_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tbe_decoder (
  input wire logic [11:0] word,
  tbe_dec_if.dec d
);
  always_comb begin
    d.dest = word[`TBE_DEST_BIT];
    d.slot = word[`TBE_SLOT_HI:0];
    d.pos = word[`TBE_POS_HI:`TBE_POS_LO];
    d.k9 = word[`TBE_K9_HI:0];
    d.op = tbe_pkg::TBE_OP_NONE;
    if (word[`TBE_OP6_HI:`TBE_OP3_LO] == `TBE_OP3_JUMP) begin
      d.op = tbe_pkg::TBE_OP_JUMP;
    end else if (word[`TBE_OP6_HI:`TBE_OP4_LO] == `TBE_OP4_SETBIT) begin
      d.op = tbe_pkg::TBE_OP_SETBIT;
    end else if (word[`TBE_OP6_HI:`TBE_OP4_LO] == `TBE_OP4_SKIPLOW) begin
      d.op = tbe_pkg::TBE_OP_SKIPLOW;
    end else if (word[`TBE_OP6_HI:`TBE_OP4_LO] == `TBE_OP4_SKIPHIGH) begin
      d.op = tbe_pkg::TBE_OP_SKIPHIGH;
    end else begin
      // Only opcode bits select; operand bits never steer decode
      unique case (word[`TBE_OP6_HI:`TBE_OP6_LO])
        `TBE_OP6_INVERT: d.op = tbe_pkg::TBE_OP_INVERT;
        `TBE_OP6_DEC: d.op = tbe_pkg::TBE_OP_DEC;
        `TBE_OP6_DECSKIP: d.op = tbe_pkg::TBE_OP_DECSKIP;
        `TBE_OP6_INC: d.op = tbe_pkg::TBE_OP_INC;
        default: d.op = tbe_pkg::TBE_OP_NONE;
      endcase
    end
  end
endmodule : tbe_decoder
`default_nettype wire

// ===== verification/tbe_partner.sv
// File register model facing the executor
`timescale 1ns/10ps
`default_nettype none
module tbe_partner (
  input wire logic clk,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  output logic [7:0] file_rdata
);
  logic [7:0] regs [32];
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
  end
  assign file_rdata = regs[file_addr];
  always @(posedge clk) begin
    if (file_we) begin
      regs[file_addr] <= file_wdata;
    end
  end
endmodule : tbe_partner
`default_nettype wire

// ===== verification/tbe_executor_bench.sv
// Self-checking bench for the instruction executor
`timescale 1ns/10ps
`default_nettype none
module tbe_executor_bench;
  typedef struct packed {
    logic [11:0] w;
    logic [7:0] v;
    logic [7:0] r;
    logic [4:0] f;
  } tbe_case_type;
  logic clk;
  logic arst_n;
  logic timed;
  logic [11:0] instr;
  logic [11:0] pass_word;
  logic [7:0] status_in;
  logic [7:0] file_rdata;
  logic [7:0] file_wdata;
  logic [7:0] acc_out;
  logic [4:0] file_addr;
  logic [10:0] pc_load;
  logic file_we, acc_we, null_flag, null_we, pc_we, fetch_req, squash, pass_valid;
  logic [15:0] cap [12];
  tbe_case_type tab [12];
  int n_mismatch;
  int check_count;
  ////////////////////////////////////////
  tbe_executor u_tbe_executor (.clk(clk), .arst_n(arst_n), .instr(instr),
    .file_rdata(file_rdata), .status_in(status_in), .acc_in(8'h00),
    .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .acc_out(acc_out), .acc_we(acc_we), .null_flag(null_flag), .null_we(null_we),
    .pc_load(pc_load), .pc_we(pc_we), .fetch_req(fetch_req), .squash(squash),
    .pass_word(pass_word), .pass_valid(pass_valid));
  tbe_partner u_tbe_partner (.clk(clk), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .file_rdata(file_rdata));
  ////////////////////////////////////////
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits for cycle end, grabs the finished word's results, presents w
  task automatic step(input logic [11:0] w);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 12) begin
        n_mismatch++;
        wrap_up();
      end
    end while (fetch_req !== 1'b1);
    if (timed) chk(16'(n), 16'h0004);
    timed = 1'b1;
    cap = '{16'(file_we), 16'(file_wdata), 16'(acc_we), 16'(acc_out),
      16'(null_we), 16'(null_flag), 16'(pc_we), 16'(pc_load), 16'(squash),
      16'(pass_valid), 16'(pass_word), 16'(file_addr)};
    instr = w;
  endtask : step
  task automatic run(input logic [11:0] w);
    step(w);
    step(12'h000);
  endtask : run
  ////////////////////////////////////////
  task automatic t_table();
    tab = '{'{12'h5E3, 8'h0A, 8'h8A, 5'h10}, '{12'h245, 8'h13, 8'hEC, 5'h0C},
      '{12'h27E, 8'hFF, 8'h00, 5'h16}, '{12'h0E6, 8'h01, 8'h00, 5'h16},
      '{12'h2C7, 8'h01, 8'h00, 5'h09}, '{12'h2FF, 8'h03, 8'h02, 5'h10},
      '{12'h2A8, 8'hFF, 8'h00, 5'h16}, '{12'h289, 8'h7F, 8'h80, 5'h0C},
      '{12'h624, 8'hFD, 8'h00, 5'h01}, '{12'h604, 8'hFD, 8'h00, 5'h00},
      '{12'h724, 8'hFD, 8'h00, 5'h00}, '{12'h704, 8'hFD, 8'h00, 5'h01}};
    foreach (tab[i]) begin
      u_tbe_partner.regs[tab[i].w[4:0]] = tab[i].v;
      run(tab[i].w);
      chk(16'({cap[0][0], cap[2][0]}), 16'(tab[i].f[4:3]));
      chk(16'({cap[4][0], cap[4][0] & cap[5][0]}), 16'(tab[i].f[2:1]));
      chk(cap[8], 16'(tab[i].f[0]));
      chk(cap[9], 16'h0000);
      chk(cap[11], 16'(tab[i].w[4:0]));
      if (tab[i].f[4]) chk(cap[1], 16'(tab[i].r));
      if (tab[i].f[3]) chk(cap[3], 16'(tab[i].r));
    end
  endtask : t_table
  task automatic t_squash();
    u_tbe_partner.regs[4] = 8'hFD;
    step(12'h624);
    step(12'h2A4);
    chk(cap[8], 16'h0001);
    step(12'h000);
    chk(cap[0], 16'h0000);
    chk(cap[9], 16'h0000);
    chk(16'(u_tbe_partner.regs[4]), 16'h00FD);
  endtask : t_squash
  task automatic t_jump();
    for (int p = 0; p < 4; p++) begin
      status_in = {1'b1, p[1:0], 5'h15};
      run(12'hBA5);
      chk(cap[7], 16'({p[1:0], 9'h1A5}));
      chk(cap[6], 16'h0001);
      chk(cap[8], 16'h0001);
      chk(cap[4], 16'h0000);
    end
  endtask : t_jump
  task automatic t_pass();
    run(12'hC55);
    chk(cap[9], 16'h0001);
    chk(cap[10], 16'h0C55);
    chk(16'({cap[0][0], cap[2][0], cap[6][0]}), 16'h0000);
  endtask : t_pass
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    instr = 12'h000;
    status_in = 8'h00;
    timed = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    t_table();
    t_squash();
    t_jump();
    t_pass();
    wrap_up();
  end
endmodule : tbe_executor_bench
`default_nettype wire
